// ---- logic/eeprom_target.sv ----
// Two-wire serial EEPROM target: addressing, byte and page write, polling.
// Assumes scl/sda at bus levels, straps and protect as static pins.
// Overview of operation
// (R1) Data falling while clock high is a start; each command begins with one.
// (R2) Data rising while clock high is a stop; ends activity, enters standby; the sequencer here ignores stops.
// (R3) Data changes only with clock low; changes with clock high are conditions.
// (R4) Bits sampled on rising clock, driven out on falling clock.
// (R5) Words are eight bits; ninth clock carries a low acknowledge.
// (R6) Controller sends a device address word with a fixed four-bit preamble.
// (R7) Next three bits must equal the three strap pins.
// (R8) Floating straps read as low; the code samples the strap pins as driven, with no pull-down.
// (R9) Eighth address bit high selects read, low selects write.
// (R10) Matching address acknowledged low; mismatch stays silent and idles.
// (R11) Write-protect high blocks all array writes.
// (R12) Word address is fourteen or fifteen bits, pages of 64 bytes.
// (R13) Write: device address, word address, data byte, each acknowledged, then stop.
// (R14) Stop after a write starts a self-timed program cycle ignoring the bus.
// (R15) Program cycle lasts at most five milliseconds.
// (R16) Page write takes up to 63 further bytes before the stop.
// (R17) Only low six address bits step after each byte.
// (R18) Passing the page end wraps to the page start.
// (R19) Over 64 bytes wraps and overwrites earlier bytes of that write.
// (R20) Address polling is acknowledged only after programming ends.
// (R21) Standby at power-up and after stop once work is done.
// (R22) Controller recovers the bus with up to nine clocks then a start.
// (R23) Data line only pulled low or released.
// (R24) Address counter holds last address plus one between operations.
// (R25) Device preamble is binary 1010.
// (R26) After a mismatch all activity is ignored until the next start.
`timescale 1ns/100ps
module eeprom_target
    import eeprom_pkg::*;
#(
    parameter int ADDR_W      = ADDR_W_LARGE,
    parameter int prog_cycles = PROG_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              scl,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    input  wire logic [2:0]        chip_select_straps,
    input  wire logic              wp,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic [BYTE_W-1:0]      peek_data,
    output logic                   standby
);
    localparam int ROW_W = ADDR_W - PAGE_IDX_W; // (R12)

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              start_tgl;
    logic              stop_tgl;
    logic              start_seen;
    logic              start_pend;
    logic [3:0]        cnt;
    logic [7:0]        shift;
    logic [7:0]        next_byte;
    link_state_t       st;
    logic              ack_ok;
    logic [7:0]        addr_hi;
    logic [ADDR_W-1:0] word_addr;
    logic              has_data;
    logic              busy_m;
    logic              busy_s;
    logic [2:0]        cs_m;
    logic [2:0]        cs_s;

    page_if #(
        .PAGE_ROW_W (ROW_W)
    ) pg ();

    function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] cs);
        return (b[7:4] == DEV_PREAMBLE) && (b[3:1] == cs);
    endfunction

    // ------------------------------------------------------------
    // Conditions and program engine
    // ------------------------------------------------------------
    bus_condition_detect u_cond (
        .rst       (rst),
        .scl       (scl),
        .sda       (sda_in),
        .start_tgl (start_tgl),
        .stop_tgl  (stop_tgl)
    );

    program_engine #(
        .ADDR_W      (ADDR_W),
        .prog_cycles (prog_cycles)
    ) u_prog (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .stop_tgl  (stop_tgl),
        .wp        (wp),
        .pg        (pg.engine),
        .peek_addr (peek_addr),
        .peek_data (peek_data),
        .standby   (standby)
    );

    // ------------------------------------------------------------
    // Crossings into the serial clock domain
    // ------------------------------------------------------------
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            busy_m <= 1'b0;
            busy_s <= 1'b0;
            cs_m   <= 3'h0;
            cs_s   <= 3'h0;
        end else begin
            busy_m <= pg.busy;
            busy_s <= busy_m;
            cs_m   <= chip_select_straps; // (R8)
            cs_s   <= cs_m;
        end
    end

    // Start toggle is steady through a whole clock low phase
    assign start_pend = (start_tgl != start_seen);
    assign next_byte  = {shift[6:0], sda_in};

    // ------------------------------------------------------------
    // Bit counter and shifter
    // ------------------------------------------------------------
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            start_seen <= 1'b0;
            cnt        <= 4'h0;
            shift      <= 8'h00;
        end else if (start_pend) begin // (R1)
            start_seen <= start_tgl;
            cnt        <= FIRST_BIT;
            shift      <= {7'h00, sda_in};
        end else if (cnt == ACK_SLOT) begin // (R5)
            cnt <= 4'h0;
        end else begin
            cnt   <= cnt + 1'b1; // (R4)
            shift <= next_byte;
        end
    end

    // ------------------------------------------------------------
    // Protocol sequencer
    // ------------------------------------------------------------
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            st     <= s_idle; // (R21)
            ack_ok <= 1'b0;
        end else if (start_pend) begin
            st     <= s_dev;
            ack_ok <= 1'b0;
        end else if (cnt == LAST_BIT) begin
            unique case (st)
                s_dev: begin
                    if (dev_hit(next_byte, cs_s) && !busy_s) begin // (R6) (R7) (R20)
                        ack_ok <= 1'b1; // (R10)
                        st     <= next_byte[0] ? s_read : s_addr_hi; // (R9)
                    end else begin
                        ack_ok <= 1'b0;
                        st     <= s_ignore; // (R10) (R26)
                    end
                end
                s_addr_hi: begin
                    ack_ok <= 1'b1; // (R13)
                    st     <= s_addr_lo;
                end
                s_addr_lo: begin
                    ack_ok <= 1'b1;
                    st     <= s_data;
                end
                s_data: begin
                    ack_ok <= 1'b1; // (R16)
                end
                s_idle, s_read, s_ignore: begin
                    ack_ok <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Word address and page buffer
    // ------------------------------------------------------------
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            addr_hi       <= 8'h00;
            word_addr     <= '0;
            has_data      <= 1'b0;
            pg.page_data  <= '0;
            pg.page_valid <= '0;
            pg.page_row   <= '0;
            pg.wr_seq     <= 1'b0;
        end else if (start_pend) begin
            has_data <= 1'b0;
        end else if (cnt == LAST_BIT) begin
            if (st == s_addr_hi) begin
                addr_hi <= next_byte;
            end
            if (st == s_addr_lo) begin
                word_addr     <= ADDR_W'({addr_hi, next_byte}); // (R12)
                pg.page_valid <= '0;
            end
            if (st == s_data) begin
                // Slot index wraps inside the page (R19)
                pg.page_data[word_addr[PAGE_IDX_W-1:0]*BYTE_W +: BYTE_W] <= next_byte;
                pg.page_valid[word_addr[PAGE_IDX_W-1:0]] <= 1'b1;
                pg.page_row <= word_addr[ADDR_W-1:PAGE_IDX_W];
                word_addr[PAGE_IDX_W-1:0] <= word_addr[PAGE_IDX_W-1:0] + 1'b1; // (R17) (R18) (R24)
                if (!has_data) begin
                    pg.wr_seq <= ~pg.wr_seq; // (R14)
                    has_data  <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Open-drain acknowledge driver
    // ------------------------------------------------------------
    assign sda_out = 1'b0; // (R23)

    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            sda_oe_n <= 1'b1;
        end else begin
            sda_oe_n <= !((cnt == ACK_SLOT) && ack_ok); // (R4) (R5)
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ack_slot: assert property (@(posedge scl) disable iff (rst) // R5
        !sda_oe_n |-> cnt == ACK_SLOT) else $error("ack driven outside ninth clock");

    a_ack_on_match: assert property (@(posedge scl) disable iff (rst) // R10
        st == s_dev && cnt == LAST_BIT && !start_pend && !busy_s && dev_hit(next_byte, cs_s)
        |=> !sda_oe_n) else $error("matching address not acknowledged");

    a_busy_nack: assert property (@(posedge scl) disable iff (rst) // R20
        st == s_dev && cnt == LAST_BIT && !start_pend && busy_s
        |=> sda_oe_n && st == s_ignore) else $error("address acknowledged while busy");

    a_ignore_hold: assert property (@(posedge scl) disable iff (rst) // R26
        st == s_ignore && !start_pend |=> st == s_ignore && sda_oe_n)
        else $error("activity answered after mismatch");

    a_rw_select: assert property (@(posedge scl) disable iff (rst) // R9
        st == s_dev && cnt == LAST_BIT && !start_pend && !busy_s && dev_hit(next_byte, cs_s)
        |=> (st == s_read) == $past(next_byte[0])) else $error("wrong operation selected");

    a_page_wrap: assert property (@(posedge scl) disable iff (rst) // R17
        st == s_data && cnt == LAST_BIT && !start_pend
        |=> word_addr[ADDR_W-1:PAGE_IDX_W] == $past(word_addr[ADDR_W-1:PAGE_IDX_W])
            && word_addr[PAGE_IDX_W-1:0] == $past(word_addr[PAGE_IDX_W-1:0]) + 1'b1)
        else $error("page address step wrong");

    a_start_restart: assert property (@(posedge scl) disable iff (rst) // R1
        start_pend |=> st == s_dev && cnt == FIRST_BIT) else $error("start not taken");

endmodule

// ---- logic/eeprom_pkg.sv ----
// Shared constants and types for the two-wire EEPROM target.
// Assumes a 10 MHz reference clock and a serial clock from the bus controller.
package eeprom_pkg;

    // ------------------------------------------------------------
    // Memory organisation
    // ------------------------------------------------------------
    localparam int ADDR_W_SMALL = 14;
    localparam int ADDR_W_LARGE = 15;
    localparam int PAGE_BYTES   = 64;
    localparam int PAGE_IDX_W   = 6;
    localparam int BYTE_W       = 8;

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    localparam logic [3:0] DEV_PREAMBLE = 4'ha; // (R25)
    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    localparam logic [3:0] FIRST_BIT    = 4'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PROG_TIME_MS = 5;
    localparam int REF_CLK_HZ   = 10_000_000;
    localparam int PROG_CYCLES  = PROG_TIME_MS * (REF_CLK_HZ / 1000);

    typedef enum logic [2:0] {
        s_idle,
        s_dev,
        s_addr_hi,
        s_addr_lo,
        s_data,
        s_read,
        s_ignore
    } link_state_t;

endpackage

// ---- logic/page_if.sv ----
// Page buffer hand-over between the serial side and the program engine.
// Serial side fills it; engine copies it after a stop unless write-protect is high, then reports busy.
`timescale 1ns/100ps
interface page_if
    import eeprom_pkg::*;
#(
    parameter int PAGE_ROW_W = 9
) ();
    logic [PAGE_BYTES*BYTE_W-1:0] page_data;
    logic [PAGE_BYTES-1:0]        page_valid;
    logic [PAGE_ROW_W-1:0]        page_row;
    logic                         wr_seq;
    logic                         busy;

    modport link (
        output page_data,
        output page_valid,
        output page_row,
        output wr_seq,
        input  busy
    );

    modport engine (
        input  page_data,
        input  page_valid,
        input  page_row,
        input  wr_seq,
        output busy
    );
endinterface

// ---- logic/bus_condition_detect.sv ----
// Start and stop detection on data-line edges while the clock is high.
// Assumes bus levels on scl and sda; outputs are toggles, one per event.
`timescale 1ns/100ps
module bus_condition_detect (
    input  wire logic rst,
    input  wire logic scl,
    input  wire logic sda,
    output logic      start_tgl,
    output logic      stop_tgl
);

    // ------------------------------------------------------------
    // Falling data edge with clock high
    // ------------------------------------------------------------
    always_ff @(negedge sda or posedge rst) begin
        if (rst) begin
            start_tgl <= 1'b0;
        end else if (scl) begin // (R1) (R3)
            start_tgl <= ~start_tgl;
        end
    end

    // ------------------------------------------------------------
    // Rising data edge with clock high
    // ------------------------------------------------------------
    always_ff @(posedge sda or posedge rst) begin
        if (rst) begin
            stop_tgl <= 1'b0;
        end else if (scl) begin // (R2) (R3)
            stop_tgl <= ~stop_tgl;
        end
    end

endmodule

// ---- logic/program_engine.sv ----
// Self-timed programming of the page buffer into the array.
// Runs on ref_clk; stop, write sequence and protect level arrive async.
`timescale 1ns/100ps
module program_engine
    import eeprom_pkg::*;
#(
    parameter int ADDR_W      = ADDR_W_LARGE,
    parameter int prog_cycles = PROG_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              stop_tgl,
    input  wire logic              wp,
    page_if.engine                 pg,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic [BYTE_W-1:0]      peek_data,
    output logic                   standby
);
    localparam int TIMER_W = $clog2(prog_cycles + 1);

    logic [BYTE_W-1:0]  mem [2**ADDR_W];
    logic               stop_m, stop_s, stop_seen;
    logic               wr_m, wr_s, wr_done;
    logic               wp_m, wp_s;
    logic [TIMER_W-1:0] timer;
    logic               commit;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {stop_s, stop_m, wr_s, wr_m, wp_s, wp_m} <= 6'h00;
        end else begin
            {stop_s, stop_m} <= {stop_m, stop_tgl};
            {wr_s, wr_m}     <= {wr_m, pg.wr_seq};
            {wp_s, wp_m}     <= {wp_m, wp};
        end
    end

    // New write data seen and the stop that ends it
    assign commit = (stop_s != stop_seen) && (wr_s != wr_done) && !pg.busy; // (R14)

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_seen <= 1'b0;
            wr_done   <= 1'b0;
        end else begin
            stop_seen <= stop_s;
            if (commit) begin
                wr_done <= wr_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Array update and timer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (commit && !wp_s) begin // (R11)
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pg.page_valid[i]) begin
                    mem[{pg.page_row, PAGE_IDX_W'(i)}] <= pg.page_data[i*BYTE_W +: BYTE_W];
                end
            end
        end
        peek_data <= mem[peek_addr];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pg.busy <= 1'b0;
            timer   <= '0;
            standby <= 1'b1;
        end else begin
            if (commit && !wp_s) begin // (R14) (R15)
                pg.busy <= 1'b1;
                timer   <= TIMER_W'(prog_cycles - 1);
            end else if (pg.busy) begin
                if (timer == '0) begin
                    pg.busy <= 1'b0;
                end else begin
                    timer <= timer - 1'b1;
                end
            end
            standby <= !pg.busy; // (R21)
        end
    end

    a_wp_guard: assert property (@(posedge ref_clk) disable iff (rst) // R11
        $rose(pg.busy) |-> !$past(wp_s)) else $error("programming started while protected");
    a_prog_bound: assert property (@(posedge ref_clk) disable iff (rst) // R15
        pg.busy |-> timer < TIMER_W'(prog_cycles)) else $error("program timer over limit");
    a_prog_ends: assert property (@(posedge ref_clk) disable iff (rst) // R15
        pg.busy && timer == '0 |=> !pg.busy) else $error("program cycle did not end");

endmodule

// ---- tb/bus_ctrl_model.sv ----
// Behavioural two-wire bus controller driving the serial clock and data.
// Assumes an external pull-up: sda_drv high means the line is released.
`timescale 1ns/100ps
module bus_ctrl_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    localparam int QTR = 20;

    // ------------------------------------------------------------
    // Idle: clock stands high, data released
    // ------------------------------------------------------------
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // ------------------------------------------------------------
    // Conditions and bits
    // ------------------------------------------------------------
    task automatic start_cond();
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic stop_cond();
        sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #QTR;
    endtask

    // MSB first, data set only while clock low
    task automatic send_byte(input logic [7:0] b, output logic ack, output logic rel);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #QTR scl = 1'b1;
            #(2*QTR) scl = 1'b0;
            #QTR;
        end
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR ack = (sda === 1'b0);
        #QTR scl = 1'b0;
        #QTR rel = (sda === 1'b1);
    endtask

    // Clock until data seen high, then a start
    task automatic recover();
        logic done;
        done    = 1'b0;
        sda_drv = 1'b1;
        for (int n = 0; n < 9 && !done; n++) begin
            scl = 1'b0;
            #(2*QTR) scl = 1'b1;
            #QTR done = (sda === 1'b1);
            #QTR;
        end
        start_cond();
        stop_cond();
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the two-wire EEPROM target.
// Assumes a shortened program cycle and a pull-up on the data line.
`timescale 1ns/100ps
module tb_top;
    import eeprom_pkg::*;
    localparam int AW = ADDR_W_LARGE;
    localparam int PC = 40;

    logic            ref_clk;
    logic            rst;
    logic            scl;
    logic            ctrl_sda;
    logic            sda_out;
    logic            sda_oe_n;
    logic [2:0]      straps;
    logic            wp;
    logic [AW-1:0]   peek_addr;
    logic [BYTE_W-1:0] peek_data;
    logic            standby;
    int              fails;
    int              checks_done;
    wire             sda_bus = ctrl_sda & (sda_oe_n ? 1'b1 : sda_out);

    eeprom_target #(.ADDR_W(AW), .prog_cycles(PC)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .chip_select_straps(straps), .wp(wp),
        .peek_addr(peek_addr), .peek_data(peek_data), .standby(standby));

    bus_ctrl_model ctrl_u (.scl(scl), .sda_drv(ctrl_sda), .sda(sda_bus));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic set_pins(input logic [2:0] s, input logic w);
        @(posedge ref_clk);
        #1 straps = s;
        wp = w;
    endtask

    task automatic frame_dev(input logic [3:0] pre, input logic [2:0] sel, input logic rw,
                             output logic a);
        logic r;
        #600 ctrl_u.start_cond();
        ctrl_u.send_byte({pre, sel, rw}, a, r);
    endtask

    task automatic do_write(input logic [AW-1:0] addr, input int n, input logic [7:0] base);
        logic        a;
        logic        r;
        logic [15:0] wa;
        wa = 16'(addr);
        frame_dev(DEV_PREAMBLE, straps, 1'b0, a);
        check(a, 1);
        ctrl_u.send_byte(wa[15:8], a, r);
        check({a, r}, 2'b11);
        ctrl_u.send_byte(wa[7:0], a, r);
        check(a, 1);
        for (int i = 0; i < n; i++) begin
            ctrl_u.send_byte(base + 8'(i), a, r);
            check(a, 1);
        end
        ctrl_u.stop_cond();
    endtask

    task automatic wait_prog(input logic exp_busy);
        logic seen;
        int   low;
        seen = 1'b0;
        low  = 0;
        for (int i = 0; i < PC + 60; i++) begin
            @(posedge ref_clk);
            #1;
            if (standby === 1'b0) begin
                seen = 1'b1;
                low++;
            end else if (seen) begin
                break;
            end
        end
        check(seen, exp_busy);
        if (exp_busy) check(low >= PC - 1 && low <= PC + 1, 1);
        check(standby, 1);
    endtask

    task automatic peek(input logic [AW-1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1 peek_addr = a;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1 check(peek_data, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_byte_write();
        do_write(15'h0123, 1, 8'h5a);
        wait_prog(1);
        peek(15'h0123, 8'h5a);
    endtask

    task automatic sc_page_wrap();
        do_write(15'h1abe, 66, 8'h10);
        wait_prog(1);
        peek(15'h1abe, 8'h50);
        peek(15'h1abf, 8'h51);
        peek(15'h1a80, 8'h12);
        peek(15'h1abd, 8'h4f);
    endtask

    task automatic sc_poll();
        logic a;
        int   n;
        do_write(15'h0200, 1, 8'hc3);
        #1000;
        frame_dev(DEV_PREAMBLE, straps, 1'b0, a);
        ctrl_u.stop_cond();
        check(a, 0);
        n = 0;
        while (!a && n < 20) begin
            frame_dev(DEV_PREAMBLE, straps, 1'b0, a);
            ctrl_u.stop_cond();
            n++;
        end
        check(a, 1);
        peek(15'h0200, 8'hc3);
    endtask

    task automatic sc_protect();
        set_pins(straps, 1'b1);
        do_write(15'h0123, 1, 8'ha5);
        wait_prog(0);
        peek(15'h0123, 8'h5a);
        set_pins(straps, 1'b0);
    endtask

    task automatic sc_straps();
        logic a;
        logic r;
        for (int s = 0; s < 8; s++) begin
            set_pins(3'(s), 1'b0);
            frame_dev(DEV_PREAMBLE, 3'(s), s[0], a);
            ctrl_u.stop_cond();
            check(a, 1);
            frame_dev(DEV_PREAMBLE, 3'(s) ^ 3'h4, 1'b0, a);
            check(a, 0);
            ctrl_u.send_byte(8'h00, a, r);
            ctrl_u.stop_cond();
            check(a, 0);
        end
        frame_dev(4'h5, straps, 1'b0, a);
        ctrl_u.stop_cond();
        check(a, 0);
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        fails       = 0;
        checks_done = 0;
        rst         = 1'b1;
        straps      = 3'h0;
        wp          = 1'b0;
        peek_addr   = '0;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        check(standby, 1);
        ctrl_u.recover();
        sc_byte_write();
        sc_page_wrap();
        sc_poll();
        sc_protect();
        sc_straps();
        close_out();
    end

    initial begin
        #2_000_000;
        fails++;
        close_out();
    end
endmodule
